// ==== hw/agp_command_cfg.svh ====
/*
  Constants of the port command register: offset, field positions, masks,
  reset values, code points and timing. Assumes a 100 MHz core clock.
*/
`ifndef AGP_COMMAND_CFG_SVH
`define AGP_COMMAND_CFG_SVH

// register map (byte address on the register bus)
`define AGP_CMD_OFFSET      32'h000000A8
// field positions
`define AGP_CAL_LSB         10
`define AGP_CAL_MSB         12
`define AGP_SBA_EN_BIT      9
`define AGP_PORT_EN_BIT     8
`define AGP_ABOVE4G_BIT     5
`define AGP_FW_EN_BIT       4
`define AGP_RATE_LSB        0
`define AGP_RATE_MSB        2
// writable bits; reserved and read-only bits stay zero
`define AGP_CMD_WR_MASK     32'h00001F17
// reset values per signaling mode
`define AGP_CMD_RESET_20    32'h00000000
`define AGP_CMD_RESET_30    32'h00000A00
// calibration period codes
`define AGP_CAL_4MS         3'h0
`define AGP_CAL_16MS        3'h1
`define AGP_CAL_64MS        3'h2
`define AGP_CAL_256MS       3'h3
`define AGP_CAL_NONE        3'h7
// transfer rate codes
`define AGP_RATE_CODE_B0    3'h1
`define AGP_RATE_CODE_B1    3'h2
`define AGP_RATE_CODE_B2    3'h4
// timing: shortest calibration period in ms, clock in kHz
`define AGP_CAL_BASE_MS     4
`define AGP_CLK_KHZ         100000
`define AGP_CAL_BASE_CYCLES (`AGP_CAL_BASE_MS * `AGP_CLK_KHZ)
// bus responses
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_DECERR     2'h3

`endif

// ==== hw/agp_command_pkg.sv ====
/*
  Types shared by the port command register and its calibration timer.
  Assumes the constants header is compiled alongside.
*/
package agp_command_pkg;

  // decoded transfer rate
  typedef enum logic [1:0] {
    RATE_1X      = 2'b00,
    RATE_4X      = 2'b01,
    RATE_8X      = 2'b10,
    RATE_INVALID = 2'b11
  } rate_type;

  // port configuration as seen by the datapath
  typedef struct packed {
    logic     port_enable;
    logic     sideband_enable;
    logic     fast_write_active;
    rate_type rate;
    logic     agp3_mode;
  } port_cfg_type;

endpackage : agp_command_pkg

// ==== hw/agp_cal_timer.sv ====
/*
  Periodic I/O calibration request timer.
  Assumes a period code from the command register and a run enable; the
  period is the base count times four to the power of codes 0 to 3.
*/
`timescale 1ns/1ps
`include "agp_command_cfg.svh"

module agp_cal_timer
  import agp_command_pkg::*;
#(
  parameter int unsigned UNIT_CYCLES = `AGP_CAL_BASE_CYCLES
) (
  input  wire logic       i_core_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_run,
  input  wire logic [2:0] i_code,
  output logic            o_cal_pulse
);

  // 256 ms needs 64 base units; refuse a base that overflows the counter
  generate
    if (UNIT_CYCLES < 1 || UNIT_CYCLES > 32'h03FFFFFF) begin : g_bad_unit
      $error("calibration base count out of range");
    end
  endgenerate

  logic [31:0] count_reg;
  logic [31:0] count_next;
  logic [2:0]  code_reg;
  logic [2:0]  code_next;
  logic        pulse_reg;
  logic        pulse_next;
  logic [31:0] period;
  logic        periodic;

  // period from code; reserved and no-calibration codes stop the timer
  always_comb begin
    periodic = 1'b1;
    period   = 32'(UNIT_CYCLES);
    case (i_code)
      `AGP_CAL_4MS:   period = 32'(UNIT_CYCLES);
      `AGP_CAL_16MS:  period = 32'(UNIT_CYCLES) << 2;
      `AGP_CAL_64MS:  period = 32'(UNIT_CYCLES) << 4;
      `AGP_CAL_256MS: period = 32'(UNIT_CYCLES) << 6;
      default:        periodic = 1'b0;
    endcase
  end

  // count up; restart whenever the code changes so a new period starts clean
  always_comb begin
    count_next = count_reg;
    code_next  = i_code;
    pulse_next = 1'b0;
    if (!i_run || !periodic || (i_code != code_reg)) begin
      count_next = 32'h00000000;
    end else if (count_reg >= period - 32'h00000001) begin
      count_next = 32'h00000000;
      pulse_next = 1'b1;
    end else begin
      count_next = count_reg + 32'h00000001;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_reg <= 32'h00000000;
      code_reg  <= `AGP_CAL_64MS;
      pulse_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      code_reg  <= code_next;
      pulse_reg <= pulse_next;
    end
  end

  assign o_cal_pulse = pulse_reg;

endmodule : agp_cal_timer

// ==== hw/agp_command_control.sv ====
/*
  Port command register behind an AXI4-Lite slave, with the acceptance
  gating of port operations and the calibration request timer.
  Assumes power_good and the reference comparator come from pins, and the
  operation strobes come from datapath logic on the same clock.
*/
// Operation
// - codes 000/001/010 give 4/16/64 ms
// - code 011 is 256 ms; 100-110 reserved
// - code 111 means no calibration cycles
// - sideband enable bit ignored in 3.0 mode
// - 3.0 signaling turns sideband addressing on
// - port disabled ignores all operations, sync too
// - accepted operations finish after port disable
// - 1X sideband command in flight still issued
// - enabled port takes pipe; sideband needs enable
// - above-4G enable is read-only zero
// - fast write off or 1X uses PCI
// - fast write on uses selected rate
// - 2.0 mode: 001 is 1X, 100 is 4X
// - 3.0 mode: 001 is 4X, 010 is 8X
// - reset value depends on signaling mode
// - mode latched at power good, 1 is 3.0
`timescale 1ns/1ps
`include "agp_command_cfg.svh"

module agp_command_control
  import agp_command_pkg::*;
#(
  parameter int unsigned CAL_UNIT_CYCLES = `AGP_CAL_BASE_CYCLES,
  parameter int unsigned MAX_PENDING     = 32
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  input  wire logic [31:0] i_s_axi_awaddr,
  input  wire logic        i_s_axi_awvalid,
  output logic             o_s_axi_awready,
  input  wire logic [31:0] i_s_axi_wdata,
  input  wire logic [3:0]  i_s_axi_wstrb,
  input  wire logic        i_s_axi_wvalid,
  output logic             o_s_axi_wready,
  output logic [1:0]       o_s_axi_bresp,
  output logic             o_s_axi_bvalid,
  input  wire logic        i_s_axi_bready,
  input  wire logic [31:0] i_s_axi_araddr,
  input  wire logic        i_s_axi_arvalid,
  output logic             o_s_axi_arready,
  output logic [31:0]      o_s_axi_rdata,
  output logic [1:0]       o_s_axi_rresp,
  output logic             o_s_axi_rvalid,
  input  wire logic        i_s_axi_rready,
  input  wire logic        i_power_good,
  input  wire logic        i_vref_agp3,
  input  wire logic        i_pipe_req,
  input  wire logic        i_sync_req,
  input  wire logic        i_sba_cmd_start,
  input  wire logic        i_sba_cmd_done,
  input  wire logic        i_op_done,
  output logic             o_pipe_accept,
  output logic             o_sync_accept,
  output logic             o_sba_cmd_issue,
  output logic             o_port_busy,
  output logic             o_cal_request,
  output port_cfg_type     o_port_cfg
);
  localparam int PW = $clog2(MAX_PENDING + 1);
  generate
    if (MAX_PENDING < 1 || MAX_PENDING > 255) begin : g_bad_pending
      $error("MAX_PENDING out of range");
    end
  endgenerate

  // transfer rate decode per signaling mode; any other code is invalid
  function automatic rate_type decode_rate(input logic [2:0] code, input logic mode3);
    if (!mode3) begin
      return (code == `AGP_RATE_CODE_B0) ? RATE_1X :
             (code == `AGP_RATE_CODE_B2) ? RATE_4X : RATE_INVALID;
    end
    return (code == `AGP_RATE_CODE_B0) ? RATE_4X :
           (code == `AGP_RATE_CODE_B1) ? RATE_8X : RATE_INVALID;
  endfunction : decode_rate

  // word-aligned decode of the one mapped register
  function automatic logic hit_cmd(input logic [31:0] addr);
    return {addr[31:2], 2'b00} == `AGP_CMD_OFFSET;
  endfunction : hit_cmd

  // byte-lane merge for a write
  function automatic logic [31:0] merge_write(input logic [31:0] old_val,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_val & ~m) | (data & m);
  endfunction : merge_write

  // pin synchronisers; first stage read only by the second
  logic pg_s1_reg, pg_s2_reg, pg_s3_reg;
  logic vr_s1_reg, vr_s2_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pg_s1_reg <= 1'b0;
      pg_s2_reg <= 1'b0;
      pg_s3_reg <= 1'b0;
      vr_s1_reg <= 1'b0;
      vr_s2_reg <= 1'b0;
    end else begin
      pg_s1_reg <= i_power_good;
      pg_s2_reg <= pg_s1_reg;
      pg_s3_reg <= pg_s2_reg;
      vr_s1_reg <= i_vref_agp3;
      vr_s2_reg <= vr_s1_reg;
    end
  end

  logic pg_rise;
  assign pg_rise = pg_s2_reg & ~pg_s3_reg;

  // register state, mode latch and bus handshake state
  logic [31:0] cmd_reg,     cmd_next;
  logic        mode3_reg,   mode3_next;
  logic        aw_got_reg,  aw_got_next;
  logic        w_got_reg,   w_got_next;
  logic [31:0] awaddr_reg,  awaddr_next;
  logic [31:0] wdata_reg,   wdata_next;
  logic [3:0]  wstrb_reg,   wstrb_next;
  logic        awready_reg, awready_next;
  logic        wready_reg,  wready_next;
  logic        bvalid_reg,  bvalid_next;
  logic [1:0]  bresp_reg,   bresp_next;
  logic        arready_reg, arready_next;
  logic        rvalid_reg,  rvalid_next;
  logic [1:0]  rresp_reg,   rresp_next;
  logic [31:0] rdata_reg,   rdata_next;

  // write path: address and data taken in either order, response after both
  always_comb begin
    cmd_next     = cmd_reg;
    mode3_next   = mode3_reg;
    aw_got_next  = aw_got_reg;
    w_got_next   = w_got_reg;
    awaddr_next  = awaddr_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg && !i_s_axi_bready;
    bresp_next   = bresp_reg;
    if (i_s_axi_awvalid && awready_reg) begin
      aw_got_next = 1'b1;
      awaddr_next = i_s_axi_awaddr;
    end
    if (i_s_axi_wvalid && wready_reg) begin
      w_got_next = 1'b1;
      wdata_next = i_s_axi_wdata;
      wstrb_next = i_s_axi_wstrb;
    end
    if (aw_got_reg && w_got_reg && !bvalid_reg) begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      if (hit_cmd(awaddr_reg)) begin
        bresp_next = `AXI_RESP_OKAY;
        cmd_next = merge_write(cmd_reg, wdata_reg, wstrb_reg) & `AGP_CMD_WR_MASK;
      end else begin
        bresp_next = `AXI_RESP_DECERR;
      end
    end
    if (pg_rise) begin
      mode3_next = vr_s2_reg;
      cmd_next   = vr_s2_reg ? `AGP_CMD_RESET_30 : `AGP_CMD_RESET_20;
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next  = !w_got_next && !bvalid_next;
  end

  // read path: one read at a time, data registered with rvalid
  always_comb begin
    arready_next = arready_reg || (rvalid_reg && i_s_axi_rready);
    rvalid_next  = rvalid_reg && !i_s_axi_rready;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (i_s_axi_arvalid && arready_reg) begin
      arready_next = 1'b0;
      rvalid_next  = 1'b1;
      if (hit_cmd(i_s_axi_araddr)) begin
        rresp_next = `AXI_RESP_OKAY;
        rdata_next = cmd_reg;
      end else begin
        rresp_next = `AXI_RESP_DECERR;
        rdata_next = 32'h00000000;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cmd_reg     <= `AGP_CMD_RESET_20;
      mode3_reg   <= 1'b0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= 32'h00000000;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `AXI_RESP_OKAY;
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `AXI_RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else begin
      cmd_reg     <= cmd_next;
      mode3_reg   <= mode3_next;
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // decoded control used by the port logic below
  logic     port_en, sba_on;
  rate_type rate_now;
  assign port_en  = cmd_reg[`AGP_PORT_EN_BIT];
  assign sba_on   = mode3_reg | cmd_reg[`AGP_SBA_EN_BIT];
  assign rate_now = decode_rate(cmd_reg[`AGP_RATE_MSB:`AGP_RATE_LSB], mode3_reg);
  // operation acceptance and in-flight tracking
  logic          pipe_acc_reg,  pipe_acc_next;
  logic          sync_acc_reg,  sync_acc_next;
  logic          sba_live_reg,  sba_live_next;
  logic          sba_issue_reg, sba_issue_next;
  logic [PW-1:0] pend_reg,      pend_next;
  logic          busy_reg,      busy_next;
  port_cfg_type  cfg_reg,       cfg_next;
  always_comb begin
    pipe_acc_next = port_en && i_pipe_req && (pend_reg != PW'(MAX_PENDING));
    sync_acc_next = port_en && i_sync_req;
    sba_live_next = sba_live_reg;
    if (i_sba_cmd_start && port_en && sba_on) begin
      sba_live_next = 1'b1;
    end
    sba_issue_next = 1'b0;
    if (i_sba_cmd_done && (sba_live_reg || (i_sba_cmd_start && port_en && sba_on))) begin
      sba_issue_next = 1'b1;
      sba_live_next  = 1'b0;
    end
    pend_next = pend_reg;
    if (pipe_acc_next && !(i_op_done && pend_reg != '0)) begin
      pend_next = pend_reg + PW'(1);
    end else if (!pipe_acc_next && i_op_done && pend_reg != '0) begin
      pend_next = pend_reg - PW'(1);
    end
    busy_next = (pend_next != '0) || sba_live_next;
    cfg_next.port_enable     = port_en;
    cfg_next.sideband_enable = sba_on;
    cfg_next.rate            = rate_now;
    cfg_next.agp3_mode       = mode3_reg;
    // pci writes when off or 1X
    cfg_next.fast_write_active = cmd_reg[`AGP_FW_EN_BIT] &&
                                 (rate_now != RATE_1X) && (rate_now != RATE_INVALID);
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pipe_acc_reg  <= 1'b0;
      sync_acc_reg  <= 1'b0;
      sba_live_reg  <= 1'b0;
      sba_issue_reg <= 1'b0;
      pend_reg      <= '0;
      busy_reg      <= 1'b0;
      cfg_reg       <= '{1'b0, 1'b0, 1'b0, RATE_INVALID, 1'b0};
    end else begin
      pipe_acc_reg  <= pipe_acc_next;
      sync_acc_reg  <= sync_acc_next;
      sba_live_reg  <= sba_live_next;
      sba_issue_reg <= sba_issue_next;
      pend_reg      <= pend_next;
      busy_reg      <= busy_next;
      cfg_reg       <= cfg_next;
    end
  end

  // calibration timer runs once the mode is latched
  // period codes
  agp_cal_timer #(.UNIT_CYCLES (CAL_UNIT_CYCLES)) u_cal_timer (
    .i_core_clk  (i_core_clk),
    .i_rst_n     (i_rst_n),
    .i_run       (pg_s3_reg),
    .i_code      (cmd_reg[`AGP_CAL_MSB:`AGP_CAL_LSB]),
    .o_cal_pulse (o_cal_request)
  );
  assign o_s_axi_awready = awready_reg;
  assign o_s_axi_wready  = wready_reg;
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign o_s_axi_arready = arready_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rresp   = rresp_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_pipe_accept   = pipe_acc_reg;
  assign o_sync_accept   = sync_acc_reg;
  assign o_sba_cmd_issue = sba_issue_reg;
  assign o_port_busy     = busy_reg;
  assign o_port_cfg      = cfg_reg;
endmodule : agp_command_control

// ==== verif/agp_master_model.sv ====
/*
  Completion side of the graphics master: retires accepted pipe operations
  one at a time, promptly or slowly. Assumes accept pulses from the port.
*/
`timescale 1ns/1ps
module agp_master_model (
  input  wire logic i_core_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pipe_accept,
  input  wire logic i_hold,
  input  wire logic i_slow,
  output logic      o_op_done
);
  logic [5:0] owed_reg;
  logic [3:0] wait_reg;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      owed_reg  <= 6'h00;
      wait_reg  <= 4'h0;
      o_op_done <= 1'b0;
    end else begin
      o_op_done <= 1'b0;
      if (wait_reg != 4'h0) wait_reg <= wait_reg - 4'h1;
      if (owed_reg != 6'h00 && !i_hold && wait_reg == 4'h0) begin
        o_op_done <= 1'b1;
        wait_reg  <= i_slow ? 4'h7 : 4'h0; // slow master spaces completions
        owed_reg  <= owed_reg + {5'h00, i_pipe_accept} - 6'h01;
      end else begin
        owed_reg <= owed_reg + {5'h00, i_pipe_accept};
      end
    end
  end
endmodule : agp_master_model

// ==== verif/agp_command_control_assertions.sv ====
/*
  Port-level checker of the command register block.
  Assumes one clock domain and the bind below.
*/
`timescale 1ns/1ps
module agp_command_control_assertions
  import agp_command_pkg::*;
#(
  parameter int unsigned CAL_UNIT_CYCLES = 8
) (
  input wire logic         i_core_clk,
  input wire logic         i_rst_n,
  input wire logic         i_pipe_req,
  input wire logic         i_sync_req,
  input wire logic         i_sba_cmd_done,
  input wire logic         o_pipe_accept,
  input wire logic         o_sync_accept,
  input wire logic         o_sba_cmd_issue,
  input wire logic         o_cal_request,
  input wire logic         o_s_axi_rvalid,
  input wire logic [31:0]  o_s_axi_rdata,
  input wire port_cfg_type o_port_cfg
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] gap_reg;
  logic [15:0] gap_next;
  // cycles since the last calibration pulse, zero until one is seen
  always_comb begin
    gap_next = gap_reg;
    if (o_cal_request) gap_next = 16'h0001;
    else if (gap_reg != 16'h0000 && gap_reg != 16'hFFFF) gap_next = gap_reg + 16'h0001;
  end
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) gap_reg <= 16'h0000;
    else gap_reg <= gap_next;
  end
  // cfg lags the register a cycle, so the enable is checked on both cycles
  a_pipe_refused: assert property (
    i_pipe_req && !o_port_cfg.port_enable ##1 !o_port_cfg.port_enable |-> !o_pipe_accept)
    else $error("pipe operation accepted while port disabled");
  a_sync_refused: assert property (
    i_sync_req && !o_port_cfg.port_enable ##1 !o_port_cfg.port_enable |-> !o_sync_accept)
    else $error("sync accepted while port disabled");
  a_sync_taken: assert property (
    i_sync_req && o_port_cfg.port_enable ##1 o_port_cfg.port_enable |-> o_sync_accept)
    else $error("sync not accepted while port enabled");
  a_issue_cause: assert property (
    o_sba_cmd_issue |-> $past(i_sba_cmd_done))
    else $error("sideband issue without a finished command");
  a_above4g_zero: assert property (
    o_s_axi_rvalid |-> !o_s_axi_rdata[5])
    else $error("above 4g enable reads one");
  a_reserved_zero: assert property (
    o_s_axi_rvalid |-> (o_s_axi_rdata & 32'hFFFFE0C8) == 32'h00000000)
    else $error("reserved bits read nonzero");
  a_fw_pci: assert property (
    o_port_cfg.rate inside {RATE_1X, RATE_INVALID} |-> !o_port_cfg.fast_write_active)
    else $error("fast write active at 1x or invalid rate");
  a_sba_auto: assert property (
    o_port_cfg.agp3_mode |-> o_port_cfg.sideband_enable)
    else $error("sideband off in 3.0 mode");
  a_cal_spacing: assert property (
    o_cal_request && gap_reg != 16'h0000 |-> gap_reg >= CAL_UNIT_CYCLES)
    else $error("calibration pulses closer than the shortest period");
  c_issue: cover property (o_sba_cmd_issue);
  c_cal: cover property (o_cal_request);
  c_agp3: cover property (o_port_cfg.agp3_mode && o_port_cfg.port_enable);
endmodule : agp_command_control_assertions

bind agp_command_control agp_command_control_assertions #(
  .CAL_UNIT_CYCLES(CAL_UNIT_CYCLES)
) u_chk (
  .i_core_clk, .i_rst_n, .i_pipe_req, .i_sync_req, .i_sba_cmd_done, .o_pipe_accept,
  .o_sync_accept, .o_sba_cmd_issue, .o_cal_request, .o_s_axi_rvalid, .o_s_axi_rdata,
  .o_port_cfg
);

// ==== verif/agp_command_control_tb.sv ====
/*
  Self-checking bench of the command register: axi4-lite master tasks,
  port strobes, rate decode and calibration spacing. Assumes the master
  model retires accepted pipe operations.
*/
`timescale 1ns/1ps
`include "agp_command_cfg.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: %0h vs %0h", $time, (g), (e)); end end
module agp_command_control_tb
  import agp_command_pkg::*;
;
  localparam int unsigned UNIT = 8; // short calibration unit for simulation
  localparam logic [31:0] OFF = `AGP_CMD_OFFSET;
  localparam logic [1:0]  OK  = `AXI_RESP_OKAY;
  logic         i_core_clk, i_rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0]  awaddr, wdata, araddr, rdata, seed;
  logic [3:0]   wstrb;
  logic         awready, wready, bvalid, arready, rvalid;
  logic [1:0]   bresp, rresp;
  logic         pgood, vref, pipe, sync, sba_s, sba_d, op_done, hold, slow;
  logic         pipe_acc, sync_acc, sba_iss, busy, cal;
  port_cfg_type cfg;
  int           err_total = 0, cmp_count = 0, cyc = 0, n;
  logic [33:0]  rd_q[$];
  logic [1:0]   b_q[$];

  agp_command_control #(.CAL_UNIT_CYCLES(UNIT)) dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_s_axi_awaddr(awaddr),
    .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_wdata(wdata),
    .i_s_axi_wstrb(wstrb), .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready),
    .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
    .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
    .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_s_axi_rvalid(rvalid),
    .i_s_axi_rready(rready), .i_power_good(pgood), .i_vref_agp3(vref),
    .i_pipe_req(pipe), .i_sync_req(sync), .i_sba_cmd_start(sba_s), .i_sba_cmd_done(sba_d),
    .i_op_done(op_done), .o_pipe_accept(pipe_acc), .o_sync_accept(sync_acc),
    .o_sba_cmd_issue(sba_iss), .o_port_busy(busy), .o_cal_request(cal), .o_port_cfg(cfg));
  agp_master_model u_master (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n),
    .i_pipe_accept(pipe_acc), .i_hold(hold), .i_slow(slow), .o_op_done(op_done));

  // free-running core clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // answers are compared against the oldest note; hang guard
  always @(posedge i_core_clk) begin
    cyc++;
    if (rvalid && rready) `CHK({rresp, rdata}, rd_q.pop_front())
    if (bvalid && bready) `CHK(bresp, b_q.pop_front())
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        input logic [1:0] r);
    bit ga, gw;
    ga = 0;
    gw = 0;
    @(posedge i_core_clk);
    b_q.push_back(r);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ga && gw)) begin
      @(posedge i_core_clk);
      if (awvalid && awready) begin ga = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin gw = 1; wvalid <= 1'b0; end
    end
    do @(posedge i_core_clk); while (!bvalid);
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [31:0] a, input logic [33:0] e);
    @(posedge i_core_clk);
    rd_q.push_back(e);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge i_core_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge i_core_clk); while (!rvalid);
    rready <= 1'b0;
  endtask : axi_rd
  // one-cycle strobes {sideband, sync, pipe}; answers one cycle later
  task automatic strobe(input logic [2:0] req, input logic [2:0] e);
    @(posedge i_core_clk);
    {sba_s, sync, pipe} <= req;
    sba_d <= req[2];
    @(posedge i_core_clk);
    {sba_s, sync, pipe, sba_d} <= 4'h0;
    @(negedge i_core_clk);
    `CHK({sba_iss, sync_acc, pipe_acc}, e)
  endtask : strobe
  task automatic rate_chk(input logic [31:0] d, input logic [2:0] e);
    axi_wr(OFF, d, 4'hF, OK);
    repeat (2) @(posedge i_core_clk);
    `CHK({cfg.fast_write_active, cfg.rate}, e)
  endtask : rate_chk
  // skips a pulse that may predate the code change, then times one period
  task automatic cal_gap(input int e);
    repeat (2) do @(posedge i_core_clk); while (!cal);
    n = 0;
    do begin @(posedge i_core_clk); n++; end while (!cal && n < 2000);
    `CHK(n, e)
  endtask : cal_gap
  task automatic tally_and_finish;
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // main sequence
  initial begin
    {i_rst_n, awvalid, wvalid, bready, arvalid, rready, pgood, vref} = 8'h00;
    {pipe, sync, sba_s, sba_d, slow} = 5'h01;
    hold = 1'b1;
    {awaddr, wdata, araddr, wstrb} = 100'h0;
    seed = 32'h00000038;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    axi_rd(OFF, {OK, 32'h00000000});
    pgood <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    axi_rd(OFF, {OK, `AGP_CMD_RESET_20});
    axi_wr(OFF, 32'hFFFFFFFF, 4'hF, OK);
    axi_rd(OFF, {OK, 32'h00001F17});
    axi_wr(OFF, 32'h00000000, 4'h2, OK); // only byte lane 1
    axi_rd(OFF, {OK, 32'h00000017});
    repeat (4) begin
      seed = xs(seed);
      axi_wr(OFF, seed, 4'hF, OK);
      axi_rd(OFF, {OK, seed & `AGP_CMD_WR_MASK});
    end
    axi_wr(32'h000000AC, 32'hFFFFFFFF, 4'hF, `AXI_RESP_DECERR);
    axi_rd(32'h000000AC, {`AXI_RESP_DECERR, 32'h00000000});
    axi_rd(OFF, {OK, seed & `AGP_CMD_WR_MASK});
    axi_wr(OFF, 32'h00001C00, 4'hF, OK); // port off, no calibration
    strobe(3'h7, 3'h0);
    axi_wr(OFF, 32'h00001D00, 4'hF, OK); // port on, sideband off
    repeat (2) strobe(3'h3, 3'h3);
    strobe(3'h4, 3'h0);
    axi_wr(OFF, 32'h00001F00, 4'hF, OK);
    strobe(3'h4, 3'h4);
    @(posedge i_core_clk);
    sba_s <= 1'b1;
    @(posedge i_core_clk);
    sba_s <= 1'b0;
    axi_wr(OFF, 32'h00001C00, 4'hF, OK); // disable with a command in flight
    sba_d <= 1'b1;
    @(posedge i_core_clk);
    sba_d <= 1'b0;
    @(negedge i_core_clk);
    `CHK(sba_iss, 1'b1)
    `CHK(busy, 1'b1)
    hold <= 1'b0;
    n = 0;
    do begin @(negedge i_core_clk); n++; end while (busy && n < 40);
    `CHK(busy, 1'b0)
    rate_chk(32'h00000111, {1'b0, RATE_1X});
    rate_chk(32'h00000114, {1'b1, RATE_4X});
    rate_chk(32'h00000104, {1'b0, RATE_4X});
    rate_chk(32'h00000112, {1'b0, RATE_INVALID});
    for (int c = 0; c < 4; c++) begin
      axi_wr(OFF, 32'(c) << 10, 4'hF, OK);
      cal_gap(UNIT << (2 * c));
    end
    for (int k = 0; k < 2; k++) begin
      axi_wr(OFF, (k != 0) ? 32'h00001000 : 32'h00001C00, 4'hF, OK);
      n = 0;
      repeat (600) @(posedge i_core_clk) if (cal) n++;
      `CHK(n, 0)
    end
    i_rst_n <= 1'b0;
    pgood <= 1'b0;
    vref <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    pgood <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    axi_rd(OFF, {OK, `AGP_CMD_RESET_30});
    axi_wr(OFF, 32'h00000100, 4'hF, OK); // sideband bit left clear
    repeat (2) @(posedge i_core_clk);
    `CHK({cfg.port_enable, cfg.agp3_mode, cfg.sideband_enable}, 3'h7)
    strobe(3'h4, 3'h4);
    rate_chk(32'h00000111, {1'b1, RATE_4X});
    rate_chk(32'h00000112, {1'b1, RATE_8X});
    rate_chk(32'h00000114, {1'b0, RATE_INVALID});
    tally_and_finish();
  end
endmodule : agp_command_control_tb
